// File: dv/dps_core_properties.sv
// Purpose: port-level checks of the data-path core
// Assumes: single clock domain, synchronous active-low reset
// Notes:   pointer contents are not visible here, so windows are checked by the bench
`timescale 1ns/1ps
module dps_core_properties (
   // clock and reset
   input wire logic         ref_clk,
   input wire logic         resetn,
   // sequencer side
   input wire logic         req_valid,
   input wire logic         req_ready,
   input dps_pkg::dps_rsp_t rsp,
   // events
   input wire logic         halt_exec,
   input wire logic         watchdog_kick_instruction,
   input wire logic         watchdog_timeout,
   // memory and status
   input dps_pkg::dps_mem_t mem,
   input wire logic [7:0]   condition_flags
);
   import dps_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   property p_done_lat;
      req_valid && req_ready |=> !req_ready ##1 !req_ready ##1 (rsp.done && req_ready);
   endproperty
   a_done_lat: assert property (p_done_lat)
      else $error("done not three cycles after take");
   property p_skip_done;
      rsp.skip |-> rsp.done;
   endproperty
   a_skip_done: assert property (p_skip_done)
      else $error("skip without done");
   property p_rd_take;
      mem.rd |-> $past(req_valid && req_ready);
   endproperty
   a_rd_take: assert property (p_rd_take)
      else $error("memory read not right after a take");
   property p_wr_done;
      mem.wr |-> rsp.done && !mem.rd;
   endproperty
   a_wr_done: assert property (p_wr_done)
      else $error("memory write outside the done cycle");
   property p_halt;
      halt_exec && !watchdog_timeout |=> condition_flags[5:4] == 2'b01;
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt did not set power-down");
   property p_kick;
      watchdog_kick_instruction && !halt_exec && !watchdog_timeout
         |=> condition_flags[5:4] == 2'b00;
   endproperty
   a_kick: assert property (p_kick)
      else $error("kick did not clear power flags");
   property p_tmo;
      watchdog_timeout |=> condition_flags[5];
   endproperty
   a_tmo: assert property (p_tmo)
      else $error("timeout did not set expiry");
   property p_keep;
      !(halt_exec || watchdog_kick_instruction || watchdog_timeout)
         |=> $stable(condition_flags[5:4]);
   endproperty
   a_keep: assert property (p_keep)
      else $error("power flags changed without an event");
   property p_hi_zero;
      condition_flags[7:6] == 2'b00;
   endproperty
   a_hi_zero: assert property (p_hi_zero)
      else $error("unused status bits not zero");
   c_wr: cover property (mem.wr);
   c_skip: cover property (rsp.skip);
   c_halt: cover property (halt_exec);
endmodule // dps_core_properties

bind dps_core dps_core_properties u_props (.ref_clk, .resetn, .req_valid, .req_ready, .rsp,
   .halt_exec, .watchdog_kick_instruction, .watchdog_timeout, .mem, .condition_flags);

// File: dv/dps_core_tb.sv
// Purpose: self-checking bench of the data-path core
// Assumes: one operation in flight, inputs driven 1 ns after the edge
// Notes:   memory contents are peeked and poked in the model
`timescale 1ns/1ps
module dps_core_tb;
   import dps_pkg::*;
   logic       ref_clk, resetn, req_valid, req_ready, halt_exec, skip;
   logic       watchdog_kick_instruction, watchdog_timeout;
   dps_req_t   req;
   dps_rsp_t   rsp;
   dps_mem_t   mem;
   logic [7:0] mem_rdata, accumulator, condition_flags;
   logic [55:0] r;
   int         num_errors, checks, wr_cnt, n;
   // op, status before, acc before, imm, acc after, status after, skip
   logic [55:0] tv [20] = '{
      56'h00_00_7f_01_80_0a_00, 56'h01_01_01_01_03_00_00, 56'h02_00_10_10_00_07_00,
      56'h03_00_10_0f_00_05_00, 56'h04_00_9a_00_00_01_00, 56'h05_00_0f_f0_00_04_00,
      56'h06_00_0f_f0_ff_00_00, 56'h07_04_0f_ff_f0_00_00, 56'h08_00_00_ff_00_04_00,
      56'h09_01_00_81_03_01_00, 56'h0a_00_00_81_c0_00_00, 56'h0b_00_00_80_00_01_00,
      56'h0c_01_00_00_80_00_00, 56'h0d_00_00_ff_00_04_00, 56'h0e_04_00_02_01_00_00,
      56'h10_00_55_00_55_00_01, 56'h11_00_55_00_55_00_00, 56'h12_00_00_ff_00_00_01,
      56'h13_00_00_02_01_00_00, 56'h14_00_55_00_55_00_00};

   dps_core u_dut (.ref_clk, .resetn, .req_valid, .req, .req_ready, .rsp, .halt_exec,
      .watchdog_kick_instruction, .watchdog_timeout, .mem, .mem_rdata, .accumulator,
      .condition_flags);
   dps_mem_model u_mem (.ref_clk, .mem, .mem_rdata);

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (mem.wr) wr_cnt <= wr_cnt + 1;

   task chk8(string name, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", name, e, g);
      end
   endtask

   task op(dps_op_t o, logic [7:0] a, logic [7:0] i, logic u, logic t, logic [3:0] b = 4'h0);
      int k;
      @(posedge ref_clk) #1;
      req = '{o, a, i, u, t, b};
      req_valid = 1'b1;
      @(posedge ref_clk) #1;
      req_valid = 1'b0;
      k = 0;
      do begin
         @(posedge ref_clk) #1;
         k++;
      end while (rsp.done !== 1'b1 && k < 8);
      skip = rsp.skip;
      chk8("done", 8'h01, {7'h00, rsp.done});
      // let the write strobe land in the memory model
      @(posedge ref_clk) #1;
   endtask

   task ld(logic [7:0] v);
      op(OP_MOVE, ADDR_ACC, v, 1'b1, 1'b1);
   endtask
   task st(logic [7:0] a);
      op(OP_MOVE, a, 8'h00, 1'b0, 1'b0);
   endtask
   task ldm(logic [7:0] a, logic [3:0] b = 4'h0);
      op(OP_MOVE, a, 8'h00, 1'b0, 1'b1, b);
   endtask
   task ev(logic h, logic k, logic t);
      @(posedge ref_clk) #1;
      {halt_exec, watchdog_kick_instruction, watchdog_timeout} = {h, k, t};
      @(posedge ref_clk) #1;
      {halt_exec, watchdog_kick_instruction, watchdog_timeout} = 3'b000;
   endtask

   task tally_and_finish;
      if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge ref_clk);
      num_errors++;
      tally_and_finish;
   end

   initial begin
      {req_valid, halt_exec, watchdog_kick_instruction, watchdog_timeout} = 4'h0;
      req = '0;
      resetn = 1'b0;
      repeat (6) @(posedge ref_clk);
      #1 resetn = 1'b1;
      chk8("status", 8'h00, condition_flags);
      ld(8'h80);
      st(8'h20);
      chk8("ram", 8'h80, u_mem.ram[0][8'h20]);
      n = wr_cnt;
      // immediate with a memory destination still lands in the accumulator
      op(OP_MOVE, 8'h20, 8'h11, 1'b1, 1'b0);
      chk8("imm", 8'h11, accumulator);
      chk8("writes", 8'(n), 8'(wr_cnt));
      ld(8'h20);
      st(ADDR_PTR0);
      ldm(ADDR_WIN0, 4'h3);
      chk8("win0", 8'h80, accumulator);
      ld(8'h5a);
      st(ADDR_WIN0);
      chk8("ram", 8'h5a, u_mem.ram[0][8'h20]);
      u_mem.ram[3][8'h40] = 8'h33;
      ld(8'h40);
      st(ADDR_PTR1);
      ldm(ADDR_WIN1, 4'h3);
      chk8("win1", 8'h33, accumulator);
      ldm(ADDR_PTR1);
      chk8("ptr1", 8'h40, accumulator);
      ld(8'h00);
      st(ADDR_PTR0);
      ld(8'h77);
      ldm(ADDR_WIN0);
      chk8("self", 8'h00, accumulator);
      ld(8'h77);
      n = wr_cnt;
      st(ADDR_WIN0);
      chk8("writes", 8'(n), 8'(wr_cnt));
      foreach (tv[i]) begin
         r = tv[i];
         ld(r[47:40]);
         st(ADDR_STATUS);
         ld(r[39:32]);
         op(dps_op_t'(r[52:48]), ADDR_ACC, r[31:24], 1'b1, 1'b1);
         chk8("result", r[23:16], accumulator);
         chk8("status", r[15:8], condition_flags);
         chk8("skip", r[7:0], {7'h00, skip});
      end
      ld(8'h3f);
      st(ADDR_STATUS);
      chk8("status", 8'h0f, condition_flags);
      ev(1'b1, 1'b0, 1'b0);
      chk8("status", 8'h1f, condition_flags);
      ld(8'h00);
      st(ADDR_STATUS);
      chk8("status", 8'h10, condition_flags);
      ev(1'b0, 1'b0, 1'b1);
      chk8("status", 8'h30, condition_flags);
      ev(1'b1, 1'b0, 1'b0);
      chk8("status", 8'h10, condition_flags);
      ev(1'b0, 1'b1, 1'b0);
      chk8("status", 8'h00, condition_flags);
      tally_and_finish;
   end
endmodule // dps_core_tb

// File: dv/dps_mem_model.sv
// Purpose: banked data memory that faces the core
// Assumes: read data is wanted in the cycle after the read strobe
// Notes:   read data is only valid in its answer cycle
`timescale 1ns/1ps
module dps_mem_model (
   // clock
   input  wire logic         ref_clk,
   // memory side of the core
   input  dps_pkg::dps_mem_t mem,
   output logic [7:0]        mem_rdata
);
   import dps_pkg::*;
   logic [7:0] ram [16][256];
   initial mem_rdata = 8'h00;
   always @(posedge ref_clk) begin
      if (mem.wr) begin
         ram[mem.bank][mem.addr] <= mem.wdata;
      end
      // toggles outside the answer cycle so a late sample cannot pass
      mem_rdata <= mem.rd ? ram[mem.bank][mem.addr] : ~mem_rdata;
   end
endmodule // dps_mem_model

// File: hdl/dps_addr.sv
// Purpose: resolves an operand location through the two indirect windows
// Assumes: pointers are stable while the location is in use
// Notes:   purely combinational
`timescale 1ns/1ps
module dps_addr (
   // requested location
   input  wire logic [7:0]   addr,
   input  wire logic [3:0]   bank,
   // pointer registers
   input  wire logic [7:0]   ptr0,
   input  wire logic [7:0]   ptr1,
   // resolved location
   output dps_pkg::dps_loc_t loc
);
   import dps_pkg::*;

   logic ind0;
   logic ind1;

   always_comb begin
      ind0     = (addr == ADDR_WIN0);
      ind1     = (addr == ADDR_WIN1);
      loc.addr = ind0 ? ptr0 : (ind1 ? ptr1 : addr);
      loc.bank = ind1 ? bank : BANK_DIRECT;
      loc.nul  = (ind0 || ind1) &&
                 (loc.addr == ADDR_WIN0 || loc.addr == ADDR_WIN1);
      loc.core = (loc.addr == ADDR_PTR0) || (loc.addr == ADDR_PTR1) ||
                 (loc.addr == ADDR_ACC) || (loc.addr == ADDR_STATUS);
   end

endmodule // dps_addr

// File: hdl/dps_alu.sv
// Purpose: 8-bit arithmetic and logic unit with flag generation
// Assumes: operand already selected by the core
// Notes:   upd marks which flags the operation owns
`timescale 1ns/1ps
module dps_alu (
   // operation
   input  dps_pkg::dps_op_t  op,
   input  wire logic [7:0]   acc,
   input  wire logic [7:0]   opnd,
   input  wire logic [3:0]   flags,
   // result
   output dps_pkg::dps_alu_t out
);
   import dps_pkg::*;

   // returns {wrap, zero, half, carry, sum}
   function automatic logic [11:0] add8(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci);
      logic [4:0] lo;
      logic [8:0] s;
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      s  = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      return {(a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, lo[4], s[8], s[7:0]};
   endfunction

   logic [11:0] r;
   logic [8:0]  bcd;
   logic        hi_fix;

   always_comb begin
      r         = '0;
      bcd       = {1'b0, acc};
      hi_fix    = 1'b0;
      out.res   = opnd;
      out.flags = flags;
      out.upd   = UPD_NONE;
      out.wr    = 1'b1;
      case (op)
         OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
            unique case (op)
               OP_ADD:  r = add8(acc, opnd, 1'b0);
               OP_ADDC: r = add8(acc, opnd, flags[FLG_C]);
               OP_SUB:  r = add8(acc, ~opnd, 1'b1);
               default: r = add8(acc, ~opnd, flags[FLG_C]);
            endcase
            out.res   = r[7:0];
            out.flags = r[11:8];
            out.upd   = UPD_ALL;
         end
         OP_DECADJ: begin
            if (acc[3:0] > BCD_LIMIT[3:0] || flags[FLG_HC]) begin
               bcd = bcd + BCD_FIX_LO;
            end
            hi_fix = (bcd[8:4] > BCD_LIMIT) || flags[FLG_C];
            if (hi_fix) begin
               bcd = bcd + BCD_FIX_HI;
            end
            out.res          = bcd[7:0];
            out.flags[FLG_C] = hi_fix;
            out.upd          = UPD_C;
         end
         OP_AND, OP_OR, OP_XOR, OP_INVERT: begin
            unique case (op)
               OP_AND:  out.res = acc & opnd;
               OP_OR:   out.res = acc | opnd;
               OP_XOR:  out.res = acc ^ opnd;
               default: out.res = ~opnd;
            endcase
            out.flags[FLG_Z] = (out.res == 8'h00);
            out.upd          = UPD_Z;
         end
         OP_ROTL:     out.res = {opnd[6:0], opnd[7]};
         OP_ROTR:     out.res = {opnd[0], opnd[7:1]};
         OP_ROTL_C, OP_ROTR_C: begin
            out.res          = (op == OP_ROTL_C) ? {opnd[6:0], flags[FLG_C]}
                                                 : {flags[FLG_C], opnd[7:1]};
            out.flags[FLG_C] = (op == OP_ROTL_C) ? opnd[7] : opnd[0];
            out.upd          = UPD_C;
         end
         OP_INC, OP_DEC, OP_INC_SKIP, OP_DEC_SKIP: begin
            r                = (op == OP_INC || op == OP_INC_SKIP) ? add8(opnd, 8'h00, 1'b1)
                                                                   : add8(opnd, 8'hff, 1'b0);
            out.res          = r[7:0];
            out.flags[FLG_Z] = r[10];
            out.upd          = (op == OP_INC || op == OP_DEC) ? UPD_Z : UPD_NONE;
         end
         OP_MOVE:     out.res = opnd;
         OP_SKIP_Z, OP_SKIP_NZ: out.wr = 1'b0;
         default:     out.wr = 1'b0;
      endcase
   end

endmodule // dps_alu

// File: hdl/dps_core.sv
// Purpose: data-path core: indirect windows, accumulator, ALU sequencing, status flags
// Assumes: sequencer holds req while req_ready is low; memory answers one cycle after rd
// Notes:   every operation takes three cycles from acceptance to the done pulse
`timescale 1ns/1ps
module dps_core (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         resetn,
   // operation from the sequencer
   input  wire logic         req_valid,
   input  dps_pkg::dps_req_t req,
   output logic              req_ready,
   output dps_pkg::dps_rsp_t rsp,
   // power-management events
   input  wire logic         halt_exec,
   input  wire logic         watchdog_kick_instruction,
   input  wire logic         watchdog_timeout,
   // banked data memory
   output dps_pkg::dps_mem_t mem,
   input  wire logic [7:0]   mem_rdata,
   // register view
   output logic [7:0]        accumulator,
   output logic [7:0]        condition_flags
);
   import dps_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   // sequencing and the operation in flight
   dps_state_t state;
   dps_state_t next_state;
   dps_req_t   cur;
   logic       take;
   logic       exec;

   // resolved locations and arithmetic
   dps_loc_t   loc;
   dps_loc_t   cur_loc;
   dps_alu_t   alu;

   // register contents and operand paths
   logic [7:0] pointer_zero;
   logic [7:0] pointer_one;
   logic [7:0] core_val;
   logic [7:0] src;
   logic [7:0] opnd;

   // write enables and the skip decision
   logic       mem_dst;
   logic       wr_acc;
   logic       wr_ptr0;
   logic       wr_ptr1;
   logic       wr_stat;
   logic       wr_ext;
   logic       skip_hit;

   // next values of the status register
   logic [3:0] next_low;
   logic       next_pwrdn;
   logic       next_wdexp;

   // value of a register held in this core; windows and unknowns read zero
   function automatic logic [7:0] read_core(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         ADDR_PTR0:   v = pointer_zero;
         ADDR_PTR1:   v = pointer_one;
         ADDR_ACC:    v = accumulator;
         ADDR_STATUS: v = condition_flags;
         default:     v = 8'h00;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // location resolution and arithmetic
   // ------------------------------------------------------------
   dps_addr u_addr (
      .addr (req.addr),
      .bank (req.bank),
      .ptr0 (pointer_zero),
      .ptr1 (pointer_one),
      .loc  (loc)
   );

   dps_alu u_alu (
      .op    (cur.op),
      .acc   (accumulator),
      .opnd  (opnd),
      .flags (condition_flags[3:0]),
      .out   (alu)
   );

   assign take = req_valid && req_ready;
   assign exec = (state == ST_EX);

   // ------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------
   // idle, read, execute: the read cycle gives the memory its one cycle of
   // latency even when the operand turns out to be internal
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (take) begin
               next_state = ST_RD;
            end
         end
         ST_RD: begin
            next_state = ST_EX;
         end
         ST_EX: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ready drops with the take and is back in the done cycle; an illegal state
   // also raises it so a corrupted sequencer can never hang
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         req_ready <= 1'b1;
      end else if (take) begin
         req_ready <= 1'b0;
      end else if (state != ST_RD) begin
         req_ready <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // request capture
   // ------------------------------------------------------------
   // the register value is caught at acceptance; only one operation is in flight, so only the
   // halt, kick and timeout events can change it (status bits 5:4) before the operation completes
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cur      <= '0;
         cur_loc  <= '0;
         core_val <= 8'h00;
      end else if (take) begin
         cur      <= req;
         cur_loc  <= loc;
         core_val <= read_core(loc.addr);
         if (req.use_imm) begin
            cur.to_acc <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // operand selection
   // ------------------------------------------------------------
   // a single memory operand per operation: the other side is always the accumulator,
   // so window-to-window and memory-to-memory transfers cannot be expressed
   always_comb begin
      if (cur.use_imm) begin
         src = cur.imm;
      end else if (cur_loc.core || cur_loc.nul) begin
         src = core_val;
      end else begin
         src = mem_rdata;
      end
      if (cur.op == OP_MOVE && !cur.to_acc) begin
         opnd = accumulator;
      end else begin
         opnd = src;
      end
   end

   // ------------------------------------------------------------
   // destination decode
   // ------------------------------------------------------------
   always_comb begin
      mem_dst = exec && alu.wr && !cur.to_acc && !cur_loc.nul;
      wr_acc  = (exec && alu.wr && cur.to_acc) ||
                (mem_dst && cur_loc.core && cur_loc.addr == ADDR_ACC);
      wr_ptr0 = mem_dst && cur_loc.core && cur_loc.addr == ADDR_PTR0;
      wr_ptr1 = mem_dst && cur_loc.core && cur_loc.addr == ADDR_PTR1;
      wr_stat = mem_dst && cur_loc.core && cur_loc.addr == ADDR_STATUS;
      wr_ext  = mem_dst && !cur_loc.core;
   end

   always_comb begin
      unique case (cur.op)
         OP_SKIP_Z:   skip_hit = (opnd == 8'h00);
         OP_SKIP_NZ:  skip_hit = (opnd != 8'h00);
         OP_INC_SKIP,
         OP_DEC_SKIP: skip_hit = (alu.res == 8'h00);
         default:     skip_hit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // accumulator
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         accumulator <= RST_ACC;
      end else if (wr_acc) begin
         accumulator <= alu.res;
      end
   end

   // ------------------------------------------------------------
   // pointer registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pointer_zero <= RST_PTR;
         pointer_one  <= RST_PTR;
      end else begin
         if (wr_ptr0) begin
            pointer_zero <= alu.res;
         end
         if (wr_ptr1) begin
            pointer_one <= alu.res;
         end
      end
   end

   // ------------------------------------------------------------
   // status register
   // ------------------------------------------------------------
   // bits 7:6 are never written and read zero. nothing here pushes the status
   // anywhere on calls or interrupts; software has to keep a copy itself
   always_comb begin
      next_low = condition_flags[3:0];
      if (wr_stat) begin
         next_low = alu.res[3:0];
      end
      // flags produced by the operation win over the data written to the register
      for (int i = 0; i < 4; i++) begin
         if (exec && alu.upd[i]) begin
            next_low[i] = alu.flags[i];
         end
      end
   end

   // register writes never reach these two; only the four events move them
   always_comb begin
      next_pwrdn = condition_flags[FLG_PWRDN];
      next_wdexp = condition_flags[FLG_WDEXP];
      if (watchdog_kick_instruction) begin
         next_pwrdn = 1'b0;
      end
      if (halt_exec) begin
         next_pwrdn = 1'b1;
      end
      if (watchdog_kick_instruction || halt_exec) begin
         next_wdexp = 1'b0;
      end
      // a timeout in the same cycle as a clear is kept
      if (watchdog_timeout) begin
         next_wdexp = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         condition_flags <= RST_STATUS;
      end else begin
         condition_flags <= {2'b00, next_wdexp, next_pwrdn, next_low};
      end
   end

   // ------------------------------------------------------------
   // data memory port
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         mem <= '0;
      end else begin
         mem.rd <= take && !req.use_imm && !loc.core && !loc.nul;
         mem.wr <= wr_ext;
         if (take) begin
            mem.bank <= loc.bank;
            mem.addr <= loc.addr;
         end
         if (wr_ext) begin
            mem.wdata <= alu.res;
         end
      end
   end

   // ------------------------------------------------------------
   // response to the sequencer
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rsp <= '0;
      end else begin
         rsp.done <= exec;
         rsp.skip <= exec && skip_hit;
      end
   end

endmodule // dps_core

// File: pkg/dps_pkg.sv
// Purpose: shared constants and types of the data-path and status core
// Assumes: single 10 MHz clock, synchronous active-low reset, one operation at a time
// Notes:   flag vectors are ordered {wrap, zero, half, carry}, the low nibble of the status byte
// Functional notes
// - locations 00h and 02h hold nothing; accesses redirect through a pointer register.
// - pointer_zero sits at 01h for window 00h, pointer_one at 03h for 02h.
// - a window reached through a window reads 00h and ignores writes.
// - a transfer with both ends on windows is unsupported.
// - both pointer registers are 8 bits, giving the low address of the target.
// - banks other than bank zero are reachable only through pointer_one.
// - accumulator is location 05h and the only partner of an immediate operand.
// - no memory-to-memory move; values pass through the accumulator.
// - 8-bit add, subtract, carry forms, decimal adjust, logic, rotates, inc, dec, skips.
// - every operation except moves, plain rotates and skips may update the condition flags as well as its result.
// - status register is 8 bits at 0ah holding zero, carry, half, wrap, power, expiry.
// - writes alter zero, carry, half and wrap only; power and expiry flags stay.
// - only power-up, watchdog overflow, halt and watchdog kick change power/expiry flags.
// - zero, wrap, half and carry reflect the latest operation that affects them.
// - status is never stacked on calls or interrupts; software saves it.
// - carry, bit 0, is carry out of add or no borrow; rotates through carry.
// - zero flag, bit 2, is set when an arithmetic or logic result is zero; decimal adjust and the inc/dec skip forms leave it unchanged here.
// - power-down flag, bit 4, clears at power-up or kick, sets on halt.
// - expiry flag, bit 5, clears at power-up, kick or halt, sets on timeout.

package dps_pkg;

   // ------------------------------------------------------------
   // register locations
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_WIN0   = 8'h00;
   localparam logic [7:0] ADDR_PTR0   = 8'h01;
   localparam logic [7:0] ADDR_WIN1   = 8'h02;
   localparam logic [7:0] ADDR_PTR1   = 8'h03;
   localparam logic [7:0] ADDR_ACC    = 8'h05;
   localparam logic [7:0] ADDR_STATUS = 8'h0a;
   localparam logic [3:0] BANK_DIRECT = 4'h0;

   // ------------------------------------------------------------
   // status fields, masks and reset values
   // ------------------------------------------------------------
   localparam int         FLG_C       = 0;
   localparam int         FLG_HC      = 1;
   localparam int         FLG_Z       = 2;
   localparam int         FLG_WRAP    = 3;
   localparam int         FLG_PWRDN   = 4;
   localparam int         FLG_WDEXP   = 5;
   localparam logic [3:0] UPD_ALL     = 4'hf;
   localparam logic [3:0] UPD_NONE    = 4'h0;
   localparam logic [3:0] UPD_C       = 4'h1;
   localparam logic [3:0] UPD_Z       = 4'h4;
   localparam logic [7:0] RST_ACC     = 8'h00;
   localparam logic [7:0] RST_PTR     = 8'h00;
   localparam logic [7:0] RST_STATUS  = 8'h00;
   localparam logic [4:0] BCD_LIMIT   = 5'h09;
   localparam logic [8:0] BCD_FIX_LO  = 9'h006;
   localparam logic [8:0] BCD_FIX_HI  = 9'h060;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_ADD      = 5'h00, OP_ADDC     = 5'h01, OP_SUB      = 5'h02, OP_SUBB     = 5'h03,
      OP_DECADJ   = 5'h04, OP_AND      = 5'h05, OP_OR       = 5'h06, OP_XOR      = 5'h07,
      OP_INVERT   = 5'h08, OP_ROTL     = 5'h09, OP_ROTR     = 5'h0a, OP_ROTL_C   = 5'h0b,
      OP_ROTR_C   = 5'h0c, OP_INC      = 5'h0d, OP_DEC      = 5'h0e, OP_MOVE     = 5'h0f,
      OP_SKIP_Z   = 5'h10, OP_SKIP_NZ  = 5'h11, OP_INC_SKIP = 5'h12, OP_DEC_SKIP = 5'h13
   } dps_op_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RD   = 3'b010,
      ST_EX   = 3'b100
   } dps_state_t;

   typedef struct packed {
      dps_op_t    op;
      logic [7:0] addr;
      logic [7:0] imm;
      logic       use_imm;
      logic       to_acc;
      logic [3:0] bank;
   } dps_req_t;

   typedef struct packed {
      logic [3:0] bank;
      logic [7:0] addr;
      logic       nul;
      logic       core;
   } dps_loc_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [3:0] bank;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dps_mem_t;

   typedef struct packed {
      logic done;
      logic skip;
   } dps_rsp_t;

   typedef struct packed {
      logic [7:0] res;
      logic [3:0] flags;
      logic [3:0] upd;
      logic       wr;
   } dps_alu_t;

endpackage
